/* File: core/mac_pkg.sv */
// constants, widths and instruction forms shared by the dual mac datapath
// assumes a 16-bit data memory word and 40-bit accumulators
package mac_pkg;
  localparam int WORD_W = 16;
  localparam int EXT_W = 17;
  localparam int MUL_W = 34;
  localparam int PROD_W = 32;
  localparam int ACC_W = 40;
  localparam int SUM_W = 41;
  localparam int ADDR_W = 24;
  localparam int UNITS = 2;
  localparam int ACC_SHIFT = 16;
  localparam int ACC_SIGN_BIT = 39;
  localparam int NARROW_SIGN_BIT = 31;
  localparam int ROUND_BIT = 16;
  localparam int UNIT_ONE = 0;
  localparam int UNIT_TWO = 1;

  localparam logic [EXT_W-1:0] MIN_EXT = 17'h18000;
  localparam logic [PROD_W-1:0] PROD_SAT_POS = 32'h7fffffff;
  localparam logic [SUM_W-1:0] ROUND_HALF = 41'h00000008000;
  localparam logic [WORD_W-1:0] ROUND_TIE = 16'h8000;
  localparam logic [WORD_W-1:0] LOW_CLEAR = 16'h0000;
  localparam logic [ACC_W-1:0] SAT40_POS = 40'h7fffffffff;
  localparam logic [ACC_W-1:0] SAT40_NEG = 40'h8000000000;
  localparam logic [ACC_W-1:0] SAT32_POS = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT32_NEG = 40'hff80000000;
  localparam logic [ACC_W-1:0] ACC_RESET = 40'h0000000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [ADDR_W-1:0] PAIR_FLIP = 24'h000001;

  typedef enum logic [2:0] {
    FORM_DUAL = 3'b000,
    FORM_DUAL_FIRST_SHIFT = 3'b001,
    FORM_DUAL_BOTH_SHIFT = 3'b010,
    FORM_LONG = 3'b100,
    FORM_LONG_FIRST_SHIFT = 3'b101,
    FORM_LONG_BOTH_SHIFT = 3'b110
  } form_t;
endpackage

/* File: core/mac_unit.sv */
// one multiply-accumulate lane: extend, multiply, scale, accumulate, round, saturate
// purely combinational; the caller registers the accumulator and the flags
`timescale 1ns/100ps
module mac_unit (
  // operands
  input wire logic [mac_pkg::WORD_W-1:0] op_a,
  input wire logic [mac_pkg::WORD_W-1:0] op_b,
  input wire logic uns_a,
  input wire logic uns_b,
  input wire logic force_sign,
  // modes
  input wire logic fractional_mode,
  input wire logic product_saturation_mode,
  input wire logic sign_extension_mode,
  input wire logic rounding_mode,
  input wire logic round_en,
  input wire logic m40_eff,
  input wire logic data_saturation_mode,
  // accumulator
  input wire logic shift_src,
  input wire logic [mac_pkg::ACC_W-1:0] acc_src,
  output logic [mac_pkg::ACC_W-1:0] acc_next,
  output logic acc_ovf,
  output logic prod_ovf
);
  import mac_pkg::*;

  function automatic logic [EXT_W-1:0] extend(input logic [WORD_W-1:0] w, input logic uns,
                                              input logic sx);
    extend = (!uns && sx) ? {w[WORD_W-1], w} : {1'b0, w};
  endfunction

  logic [EXT_W-1:0] a_ext;
  logic [EXT_W-1:0] b_ext;
  logic [MUL_W-1:0] mul;
  logic [PROD_W-1:0] prod;
  logic [ACC_W-1:0] src;
  logic [SUM_W-1:0] sum;
  logic [SUM_W-1:0] rsum;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    a_ext = extend(op_a, uns_a, sign_extension_mode | force_sign); // [RULE_02] [RULE_03]
    b_ext = extend(op_b, uns_b, sign_extension_mode | force_sign); // [RULE_02] [RULE_16]
    // context-sized signed multiply: both operands sign-extend to the full 34 bits
    mul = $signed(a_ext) * $signed(b_ext);
    if (fractional_mode) begin
      mul = {mul[MUL_W-2:0], 1'b0}; // [RULE_04]
    end
    prod_ovf = product_saturation_mode && fractional_mode && a_ext == MIN_EXT
               && b_ext == MIN_EXT; // [RULE_05]
    prod = prod_ovf ? PROD_SAT_POS : mul[PROD_W-1:0];
    src = shift_src ? {{ACC_SHIFT{acc_src[ACC_SIGN_BIT]}}, acc_src[ACC_W-1:ACC_SHIFT]}
                    : acc_src; // [RULE_07] [RULE_08]
    sum = {src[ACC_W-1], src} + {{(SUM_W-PROD_W){prod[PROD_W-1]}}, prod}; // [RULE_06]
    rsum = sum;
    if (round_en) begin
      rsum = sum + ROUND_HALF; // [RULE_09]
      if (rounding_mode && sum[WORD_W-1:0] == ROUND_TIE) begin
        rsum[ROUND_BIT] = 1'b0;
      end
      rsum[WORD_W-1:0] = LOW_CLEAR;
    end
    if (m40_eff) begin
      acc_ovf = rsum[SUM_W-1] ^ rsum[ACC_W-1]; // [RULE_10]
    end else begin
      acc_ovf = !(&rsum[SUM_W-1:NARROW_SIGN_BIT] || ~|rsum[SUM_W-1:NARROW_SIGN_BIT]);
    end
    acc_next = rsum[ACC_W-1:0];
    if (acc_ovf && data_saturation_mode) begin
      if (m40_eff) begin
        acc_next = rsum[SUM_W-1] ? SAT40_NEG : SAT40_POS; // [RULE_11]
      end else begin
        acc_next = rsum[SUM_W-1] ? SAT32_NEG : SAT32_POS; // [RULE_11]
      end
    end
  end
endmodule

/* File: core/dual_mac_datapath.sv */
// dual multiply-accumulate datapath for the paired mac instruction forms
// assumes issue and operand inputs come from logic on the same clock;
// software loads accumulators and clears flags through the plain ports
//
// Contract
// RULE_01 - both operations of a pair finish together in one cycle on two units
// RULE_02 - a zero-extend qualifier makes that operand zero-extended to 17 bits
// RULE_03 - otherwise operands sign-extend to 17 bits when sign mode set, else zero; code sign-extends them in every long form
// RULE_04 - fractional mode shifts each product left by one bit
// RULE_05 - each multiplier flags product overflow under product saturation mode
// RULE_06 - 32-bit product sign-extends to 40 bits, adds to and replaces its accumulator
// RULE_07 - first-shift form: first accumulator arithmetic right 16, second unshifted
// RULE_08 - both-shift form: each accumulator arithmetic right 16 before adding
// RULE_09 - rounding keyword rounds each result as rounding mode selects
// RULE_10 - overflow checked at guard-bit width; each op sets its own flag; code checks at 32 bits unless guard-bit mode or the 40 keyword is set
// RULE_11 - on overflow the accumulator saturates when data saturation mode is set
// RULE_12 - the 40 keyword forces guard-bit mode for that instruction only
// RULE_13 - program keeps coefficients in internal memory to avoid bus errors
// RULE_14 - aux-modify-only suppresses a lane while addresses still update
// RULE_15 - long form shares one data operand from the d bus with both units
// RULE_16 - long form high coefficient from second b bus, sign-extended, unit two
// RULE_17 - low coefficient at paired address (even +1, odd -1) on b bus, unit one
// RULE_18 - paired instructions work under repeat, every iteration
// RULE_19 - overflow flags are sticky, set here and cleared only by software
`timescale 1ns/100ps
module dual_mac_datapath (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // instruction issue
  input wire logic issue_valid,
  input wire mac_pkg::form_t form,
  input wire logic round_keyword,
  input wire logic force40_keyword,
  input wire logic aux_modify_only_first,
  input wire logic aux_modify_only_second,
  input wire logic uns_x,
  input wire logic uns_y,
  input wire logic uns_coef_first,
  input wire logic uns_coef_second,
  // status mode bits
  input wire logic fractional_mode,
  input wire logic product_saturation_mode,
  input wire logic sign_extension_mode,
  input wire logic rounding_mode,
  input wire logic guard_bit_overflow_mode,
  input wire logic data_saturation_mode,
  // read data buses
  input wire logic [mac_pkg::WORD_W-1:0] d_read_data_bus,
  input wire logic [mac_pkg::WORD_W-1:0] c_read_data_bus,
  input wire logic [mac_pkg::WORD_W-1:0] b_read_data_bus,
  input wire logic [mac_pkg::WORD_W-1:0] second_b_read_bus,
  // coefficient address request
  input wire logic coef_address_request,
  input wire logic [mac_pkg::ADDR_W-1:0] effective_address,
  output logic coef_address_strobe,
  output logic [mac_pkg::ADDR_W-1:0] b_address_bus,
  output logic [mac_pkg::ADDR_W-1:0] second_b_address_bus,
  // software access to accumulators and flags
  input wire logic acc_load_first,
  input wire logic acc_load_second,
  input wire logic [mac_pkg::ACC_W-1:0] acc_load_value,
  input wire logic clear_overflow_first,
  input wire logic clear_overflow_second,
  // results
  output logic [mac_pkg::ACC_W-1:0] accumulator_first,
  output logic [mac_pkg::ACC_W-1:0] accumulator_second,
  output logic overflow_flag_first,
  output logic overflow_flag_second,
  output logic product_overflow_first,
  output logic product_overflow_second,
  output logic result_valid
);
  import mac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // form decode
  function automatic logic is_long(input form_t f);
    is_long = (f == FORM_LONG) || (f == FORM_LONG_FIRST_SHIFT) || (f == FORM_LONG_BOTH_SHIFT);
  endfunction

  function automatic logic is_legal(input form_t f);
    unique case (f)
      FORM_DUAL, FORM_DUAL_FIRST_SHIFT, FORM_DUAL_BOTH_SHIFT: is_legal = 1'b1;
      FORM_LONG, FORM_LONG_FIRST_SHIFT, FORM_LONG_BOTH_SHIFT: is_legal = 1'b1;
      default: is_legal = 1'b0;
    endcase
  endfunction

  function automatic logic first_shifted(input form_t f);
    first_shifted = (f == FORM_DUAL_FIRST_SHIFT) || (f == FORM_DUAL_BOTH_SHIFT)
                    || (f == FORM_LONG_FIRST_SHIFT) || (f == FORM_LONG_BOTH_SHIFT);
  endfunction

  function automatic logic second_shifted(input form_t f);
    second_shifted = (f == FORM_DUAL_BOTH_SHIFT) || (f == FORM_LONG_BOTH_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand routing
  logic long_form;
  logic issue_ok;
  logic m40_eff;
  logic [WORD_W-1:0] op_a [UNITS];
  logic [WORD_W-1:0] op_b [UNITS];
  logic uns_a [UNITS];
  logic uns_b [UNITS];
  logic shift_src [UNITS];
  logic suppress [UNITS];

  always_comb begin
    long_form = is_long(form);
    issue_ok = issue_valid && is_legal(form);
    m40_eff = guard_bit_overflow_mode | force40_keyword; // [RULE_12]
    // coefficient reads are trusted to come from internal memory [RULE_13]
    op_a[UNIT_ONE] = d_read_data_bus;
    op_a[UNIT_TWO] = long_form ? d_read_data_bus : c_read_data_bus; // [RULE_15]
    op_b[UNIT_ONE] = b_read_data_bus; // [RULE_17]
    op_b[UNIT_TWO] = long_form ? second_b_read_bus : b_read_data_bus; // [RULE_16]
    uns_a[UNIT_ONE] = uns_x;
    uns_a[UNIT_TWO] = long_form ? uns_x : uns_y; // [RULE_15]
    uns_b[UNIT_ONE] = uns_coef_first;
    uns_b[UNIT_TWO] = uns_coef_second;
    shift_src[UNIT_ONE] = first_shifted(form); // [RULE_07] [RULE_08]
    shift_src[UNIT_TWO] = second_shifted(form); // [RULE_08]
    suppress[UNIT_ONE] = aux_modify_only_first; // [RULE_14]
    suppress[UNIT_TWO] = aux_modify_only_second; // [RULE_14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two multiplier lanes
  logic [ACC_W-1:0] acc_q [UNITS];
  logic [ACC_W-1:0] acc_d [UNITS];
  logic [ACC_W-1:0] lane_acc [UNITS];
  logic lane_ovf [UNITS];
  logic lane_prod_ovf [UNITS];

  for (genvar u = 0; u < UNITS; u++) begin : g_lane
    mac_unit lane (
      .op_a(op_a[u]),
      .op_b(op_b[u]),
      .uns_a(uns_a[u]),
      .uns_b(uns_b[u]),
      .force_sign(long_form),
      .fractional_mode(fractional_mode),
      .product_saturation_mode(product_saturation_mode),
      .sign_extension_mode(sign_extension_mode),
      .rounding_mode(rounding_mode),
      .round_en(round_keyword),
      .m40_eff(m40_eff),
      .data_saturation_mode(data_saturation_mode),
      .shift_src(shift_src[u]),
      .acc_src(acc_q[u]),
      .acc_next(lane_acc[u]),
      .acc_ovf(lane_ovf[u]),
      .prod_ovf(lane_prod_ovf[u])
    ); // [RULE_01]
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulators, flags and result strobe
  logic ovf_q [UNITS];
  logic ovf_d [UNITS];
  logic prod_ovf_q [UNITS];
  logic prod_ovf_d [UNITS];
  logic valid_q;
  logic valid_d;
  logic load [UNITS];
  logic clear [UNITS];

  always_comb begin
    load[UNIT_ONE] = acc_load_first;
    load[UNIT_TWO] = acc_load_second;
    clear[UNIT_ONE] = clear_overflow_first;
    clear[UNIT_TWO] = clear_overflow_second;
    valid_d = issue_ok; // [RULE_18]
    for (int u = 0; u < UNITS; u++) begin
      acc_d[u] = acc_q[u];
      prod_ovf_d[u] = 1'b0;
      ovf_d[u] = ovf_q[u] & ~clear[u]; // [RULE_19]
      if (load[u]) begin
        acc_d[u] = acc_load_value;
      end else if (issue_ok && !suppress[u]) begin
        acc_d[u] = lane_acc[u]; // [RULE_01] [RULE_06]
      end
      if (issue_ok && !suppress[u]) begin
        prod_ovf_d[u] = lane_prod_ovf[u]; // [RULE_05]
        ovf_d[u] = ovf_d[u] | lane_ovf[u]; // [RULE_10] [RULE_19]
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      for (int u = 0; u < UNITS; u++) begin
        acc_q[u] <= ACC_RESET;
        ovf_q[u] <= 1'b0;
        prod_ovf_q[u] <= 1'b0;
      end
      valid_q <= 1'b0;
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        acc_q[u] <= acc_d[u];
        ovf_q[u] <= ovf_d[u];
        prod_ovf_q[u] <= prod_ovf_d[u];
      end
      valid_q <= valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coefficient address pair for the long form
  logic strobe_q;
  logic strobe_d;
  logic [ADDR_W-1:0] lo_addr_q;
  logic [ADDR_W-1:0] lo_addr_d;
  logic [ADDR_W-1:0] hi_addr_q;
  logic [ADDR_W-1:0] hi_addr_d;

  always_comb begin
    strobe_d = coef_address_request;
    lo_addr_d = lo_addr_q;
    hi_addr_d = hi_addr_q;
    if (coef_address_request) begin
      hi_addr_d = effective_address; // [RULE_16]
      lo_addr_d = effective_address ^ PAIR_FLIP; // [RULE_17]
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      strobe_q <= 1'b0;
      lo_addr_q <= ADDR_RESET;
      hi_addr_q <= ADDR_RESET;
    end else begin
      strobe_q <= strobe_d;
      lo_addr_q <= lo_addr_d;
      hi_addr_q <= hi_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign accumulator_first = acc_q[UNIT_ONE];
  assign accumulator_second = acc_q[UNIT_TWO];
  assign overflow_flag_first = ovf_q[UNIT_ONE];
  assign overflow_flag_second = ovf_q[UNIT_TWO];
  assign product_overflow_first = prod_ovf_q[UNIT_ONE];
  assign product_overflow_second = prod_ovf_q[UNIT_TWO];
  assign result_valid = valid_q;
  assign coef_address_strobe = strobe_q;
  assign b_address_bus = lo_addr_q;
  assign second_b_address_bus = hi_addr_q;
endmodule

/* File: verification/dual_mac_checker.sv */
// port assertions for the dual mac datapath
// bound to every dual_mac_datapath instance; one clock domain
`timescale 1ns/100ps
module dual_mac_checker (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // issue and modes
  input wire logic issue_valid,
  input wire mac_pkg::form_t form,
  input wire logic aux_modify_only_first,
  input wire logic acc_load_first,
  input wire logic clear_overflow_first,
  input wire logic fractional_mode,
  input wire logic product_saturation_mode,
  input wire logic data_saturation_mode,
  // address pair
  input wire logic coef_address_request,
  input wire logic [mac_pkg::ADDR_W-1:0] effective_address,
  input wire logic coef_address_strobe,
  input wire logic [mac_pkg::ADDR_W-1:0] b_address_bus,
  input wire logic [mac_pkg::ADDR_W-1:0] second_b_address_bus,
  // results
  input wire logic [mac_pkg::ACC_W-1:0] accumulator_first,
  input wire logic overflow_flag_first,
  input wire logic product_overflow_first,
  input wire logic product_overflow_second,
  input wire logic result_valid
);
  import mac_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic issue_ok;
  assign issue_ok = issue_valid && form[1:0] != 2'b11;
  ////////////////////////////////////////
  sequence s_req;
    coef_address_request;
  endsequence
  sequence s_pair;
    coef_address_strobe && b_address_bus == ($past(effective_address) ^ PAIR_FLIP)
      && second_b_address_bus == $past(effective_address);
  endsequence
  AST_ADDR_PAIR: assert property (s_req |=> s_pair)
    else $error("address pair wrong");
  AST_STROBE_PULSE: assert property (!coef_address_request |=> !coef_address_strobe)
    else $error("strobe without request");
  AST_RESULT_NEXT: assert property (issue_ok |=> result_valid)
    else $error("result not valid after issue");
  AST_NO_RESULT: assert property (!issue_ok |=> !result_valid)
    else $error("result valid without issue");
  AST_SUPPRESS_FIRST: assert property (issue_ok && aux_modify_only_first && !acc_load_first
    |=> $stable(accumulator_first))
    else $error("suppressed lane changed");
  AST_STICKY_FIRST: assert property (overflow_flag_first && !clear_overflow_first
    |=> overflow_flag_first)
    else $error("overflow flag dropped");
  AST_PROD_MODE: assert property (!(product_saturation_mode && fractional_mode)
    |=> !product_overflow_first && !product_overflow_second)
    else $error("product overflow outside mode");
  AST_SAT_FIRST: assert property (issue_ok && !aux_modify_only_first && !acc_load_first
    && data_saturation_mode && !overflow_flag_first ##1 overflow_flag_first
    |-> accumulator_first inside {SAT40_POS, SAT40_NEG, SAT32_POS, SAT32_NEG})
    else $error("overflow without saturation");
endmodule
bind dual_mac_datapath dual_mac_checker chk (.*);

/* File: verification/coef_memory.sv */
// coefficient memory behind the b read buses
// combinational read of the registered address pair
`timescale 1ns/100ps
module coef_memory (
  // address pair
  input wire logic [mac_pkg::ADDR_W-1:0] b_address_bus,
  input wire logic [mac_pkg::ADDR_W-1:0] second_b_address_bus,
  // read data
  output logic [mac_pkg::WORD_W-1:0] b_read_data_bus,
  output logic [mac_pkg::WORD_W-1:0] second_b_read_bus
);
  import mac_pkg::*;
  // all internal: every address decodes, none faults
  assign b_read_data_bus = b_address_bus[15:0] ^ {2{b_address_bus[23:16]}};
  assign second_b_read_bus = second_b_address_bus[15:0]
    ^ {2{second_b_address_bus[23:16]}};
endmodule

/* File: verification/testbench.sv */
// random self-checking bench with a reference lane model
// coefficients come from coef_memory at the datapath's address pair
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import mac_pkg::*;
  logic clock, resetn, issue_valid, round_keyword, force40_keyword, uns_x, uns_y;
  logic aux_modify_only_first, aux_modify_only_second, uns_coef_first, uns_coef_second;
  logic fractional_mode, product_saturation_mode, sign_extension_mode, rounding_mode;
  logic guard_bit_overflow_mode, data_saturation_mode, coef_address_request;
  logic acc_load_first, acc_load_second, clear_overflow_first, clear_overflow_second;
  logic coef_address_strobe, overflow_flag_first, overflow_flag_second, result_valid;
  logic product_overflow_first, product_overflow_second, f1, f2, p1, p2, c1, c2, ev, es;
  form_t form;
  logic [WORD_W-1:0] d_read_data_bus, c_read_data_bus, b_read_data_bus, second_b_read_bus;
  logic [ADDR_W-1:0] effective_address, b_address_bus, second_b_address_bus, cur_lo, cur_hi;
  logic [ACC_W-1:0] acc_load_value, accumulator_first, accumulator_second, acc1, acc2;
  int failures = 0;
  int num_checks = 0;
  dual_mac_datapath DUT (.*);
  coef_memory mem (.*);
  always #2 clock = ~clock;
  ////////////////////////////////////////
  function automatic logic [15:0] word_at(input logic [23:0] a);
    return a[15:0] ^ {2{a[23:16]}};
  endfunction
  function automatic logic [41:0] lane(input logic [15:0] a, b, input logic ua, ub, sx, sh,
                                       input logic [39:0] acc);
    logic signed [16:0] xa, xb;
    logic signed [33:0] p;
    logic [31:0] p32;
    logic [40:0] s;
    logic [39:0] src, res;
    logic [15:0] lo;
    logic po, m40, ov;
    xa = {!ua && sx && a[15], a};
    xb = {!ub && sx && b[15], b};
    p = xa * xb;
    if (fractional_mode) p = p <<< 1;
    po = product_saturation_mode && fractional_mode && xa == MIN_EXT && xb == MIN_EXT;
    p32 = po ? PROD_SAT_POS : p[31:0];
    src = sh ? {{16{acc[39]}}, acc[39:16]} : acc;
    s = {src[39], src} + {{9{p32[31]}}, p32};
    lo = s[15:0];
    if (round_keyword) begin
      s = s + ROUND_HALF;
      s[15:0] = LOW_CLEAR;
      if (rounding_mode && lo == ROUND_TIE) s[ROUND_BIT] = 1'b0;
    end
    m40 = guard_bit_overflow_mode | force40_keyword;
    ov = m40 ? s[40] ^ s[39] : !(&s[40:31] || !(|s[40:31]));
    res = s[39:0];
    if (ov && data_saturation_mode && m40) res = s[40] ? SAT40_NEG : SAT40_POS;
    if (ov && data_saturation_mode && !m40) res = s[40] ? SAT32_NEG : SAT32_POS;
    return {po, ov, res};
  endfunction
  task automatic predict();
    logic lg, lf, sx;
    logic [41:0] r1, r2;
    lg = issue_valid && form[1:0] != 2'b11;
    lf = form[2];
    sx = lf | sign_extension_mode;
    r1 = lane(d_read_data_bus, word_at(cur_lo), uns_x, uns_coef_first, sx, |form[1:0], acc1);
    r2 = lane(lf ? d_read_data_bus : c_read_data_bus, word_at(lf ? cur_hi : cur_lo),
              lf ? uns_x : uns_y, uns_coef_second, sx, form[1], acc2);
    c1 = lg && !aux_modify_only_first;
    c2 = lg && !aux_modify_only_second;
    p1 = r1[41];
    p2 = r2[41];
    f1 = (f1 && !clear_overflow_first) || (c1 && r1[40]);
    f2 = (f2 && !clear_overflow_second) || (c2 && r2[40]);
    acc1 = acc_load_first ? acc_load_value : c1 ? r1[39:0] : acc1;
    acc2 = acc_load_second ? acc_load_value : c2 ? r2[39:0] : acc2;
    ev = lg;
    es = coef_address_request;
    if (es) cur_lo = effective_address ^ PAIR_FLIP;
    if (es) cur_hi = effective_address;
  endtask
  task automatic drive(input bit corner);
    issue_valid <= corner || $urandom % 8 != 0;
    form <= form_t'($urandom % 8);
    {round_keyword, force40_keyword, uns_x, uns_y, uns_coef_first, uns_coef_second} <= 6'($urandom);
    {rounding_mode, guard_bit_overflow_mode, data_saturation_mode} <= 3'($urandom);
    {aux_modify_only_first, aux_modify_only_second} <= {$urandom % 8 == 0, $urandom % 8 == 0};
    {acc_load_first, acc_load_second} <= {$urandom % 8 == 0, $urandom % 8 == 0};
    {clear_overflow_first, clear_overflow_second} <= {$urandom % 8 == 0, $urandom % 8 == 0};
    acc_load_value <= ACC_W'({$urandom, $urandom});
    coef_address_request <= corner || $urandom % 4 != 0;
    if (corner) begin
      {d_read_data_bus, c_read_data_bus, effective_address} <= {32'h80008000, 24'h008001};
      {fractional_mode, product_saturation_mode, sign_extension_mode} <= 3'h7;
    end else begin
      {d_read_data_bus, c_read_data_bus, effective_address} <= {$urandom, 24'($urandom)};
      {fractional_mode, product_saturation_mode, sign_extension_mode} <= 3'($urandom);
    end
  endtask
  task automatic compare();
    `CHECK("accumulator_first", acc1, accumulator_first)
    `CHECK("accumulator_second", acc2, accumulator_second)
    `CHECK("overflow_flag_first", f1, overflow_flag_first)
    `CHECK("overflow_flag_second", f2, overflow_flag_second)
    `CHECK("result_valid", ev, result_valid)
    `CHECK("coef_address_strobe", es, coef_address_strobe)
    `CHECK("b_address_bus", cur_lo, b_address_bus)
    `CHECK("second_b_address_bus", cur_hi, second_b_address_bus)
    if (c1) `CHECK("product_overflow_first", p1, product_overflow_first)
    if (c2) `CHECK("product_overflow_second", p2, product_overflow_second)
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {clock, resetn, issue_valid, round_keyword, force40_keyword, uns_x, uns_y} = '0;
    {aux_modify_only_first, aux_modify_only_second, uns_coef_first, uns_coef_second} = '0;
    {fractional_mode, product_saturation_mode, sign_extension_mode, rounding_mode} = '0;
    {guard_bit_overflow_mode, data_saturation_mode, coef_address_request} = '0;
    {acc_load_first, acc_load_second, clear_overflow_first, clear_overflow_second} = '0;
    {d_read_data_bus, c_read_data_bus, effective_address, acc_load_value} = '0;
    {f1, f2, c1, c2, p1, p2, ev, es} = '0;
    form = FORM_DUAL;
    {acc1, acc2, cur_lo, cur_hi} = {ACC_RESET, ACC_RESET, ADDR_RESET, ADDR_RESET};
    void'($urandom(32'h5f3401d9));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 800; i++) begin
      @(negedge clock);
      predict();
      @(posedge clock);
      drive(i % 8 < 2);
      #1 compare();
    end
    complete_run();
  end
endmodule
